// ### otcr_map.vh
`ifndef OTCR_MAP_VH
`define OTCR_MAP_VH

// Register offsets
`define OTCR_ADDR_INT_STATUS2     8'h42
`define OTCR_ADDR_DURATION        8'h79
`define OTCR_ADDR_LIMIT           8'h7A
`define OTCR_ADDR_PULSES          8'h7B
`define OTCR_ADDR_CONFIG          8'h7C
`define OTCR_ADDR_LOCK            8'h80
`define OTCR_ADDR_INT_MASK2       8'h81

// Reset values
`define OTCR_RST_DURATION         8'h00
`define OTCR_RST_LIMIT            8'h00
`define OTCR_RST_PULSES           8'h55
`define OTCR_RST_CONFIG           8'h01
`define OTCR_RST_INT_MASK2        8'h00
`define OTCR_RST_BYTE             8'h00

// Field positions
`define OTCR_INT_TIMER_BIT        5
`define OTCR_LOCK_BIT             0
`define OTCR_CFG_TWOS_BIT         0
`define OTCR_CFG_OFFSET_BIT       1
`define OTCR_CFG_AUX_DIR_BIT      2
`define OTCR_CFG_AUX_POL_BIT      3
`define OTCR_CFG_CODE_IO_BIT      4
`define OTCR_CFG_REMOTE_A_BIT     5
`define OTCR_CFG_LOCAL_BIT        6
`define OTCR_CFG_REMOTE_B_BIT     7

// Disabled limit codes per format
`define OTCR_LIMIT_OFF_OFFSET64   8'h00
`define OTCR_LIMIT_OFF_TWOS       8'h80

// Timing
`define OTCR_CLK_PERIOD_NS        20
`define OTCR_TICK_NS              22760000
`define OTCR_TICK_CYCLES          (`OTCR_TICK_NS / `OTCR_CLK_PERIOD_NS)
`define OTCR_MIN_REPORT_NS        45520000
`define OTCR_MIN_REPORT_TICKS     (`OTCR_MIN_REPORT_NS / `OTCR_TICK_NS)

`endif

// ### otcr_regs.v
// Behaviour
// RQ1 - Status bits 7:1 read zero until assertion lasts over 45.52 ms.
// RQ2 - Status bit 0 sets on pin assertion, clears when software reads it.
// RQ3 - Past 45.52 ms status reads eight-bit count, 22.76 ms per step.
// RQ4 - Duration beyond eight-bit limit sets timer flag, interrupt status bit 5.
// RQ5 - Limit zero raises timer flag immediately on pin assertion.
// RQ6 - Four two-bit fields select one to four speed_pulse_input pulses; default two.
// RQ7 - Format bit: one two's complement, zero offset-64; applies immediately.
// RQ8 - Offset bit: zero half-degree steps, one one-degree steps.
// RQ9 - Aux pin direction bit: zero input, one output.
// RQ10 - Aux pin polarity bit: zero active low, one active high.
// RQ11 - Pin function bit: zero voltage-ID inputs, one general-purpose I/O.
// RQ12 - Three channel enables drive the overtemp pin; all zero means input only.
// RQ13 - Limit of -64 (offset-64) or -128 (two's complement) disables channel.
// RQ14 - Configuration register resets to 0x01.
// RQ15 - Once lock is set, configuration register writes are ignored.
// RQ16 - Duration count saturates instead of wrapping.
// RQ17 - Overtemp pin input is synchronised before timing.
`timescale 1ns/1ps
`default_nettype none
`include "otcr_map.vh"

module otcr_regs #(
	parameter TICK_CYCLES = `OTCR_TICK_CYCLES,
	parameter PRESC_W     = 21
) (
	// Clock and reset
	input  wire        clk,
	input  wire        rst,
	// Register port
	input  wire [7:0]  addr,
	input  wire [7:0]  wdata,
	input  wire        wr_en,
	input  wire        rd_en,
	output reg  [7:0]  rdata,
	// Interrupt
	output wire        irq,
	// Overtemp pin, low when asserted
	input  wire        overtemp_pin_in,
	output wire        overtemp_pin_out,
	output wire        overtemp_pin_oe,
	// Channel temperatures and overtemp limits
	input  wire [7:0]  remote_a_temp,
	input  wire [7:0]  local_temp,
	input  wire [7:0]  remote_b_temp,
	input  wire [7:0]  remote_a_limit,
	input  wire [7:0]  local_limit,
	input  wire [7:0]  remote_b_limit,
	// Offset code to scale
	input  wire [7:0]  temp_offset_code,
	output reg  [8:0]  temp_offset_half,
	// Aux I/O pin
	input  wire        aux_io_enable,
	input  wire        aux_io_value,
	input  wire        aux_io_in,
	output wire        aux_io_out,
	output wire        aux_io_oe,
	output wire        aux_io_level,
	// Shared voltage-ID or I/O pins
	input  wire [4:0]  shared_pin_in,
	output reg  [4:0]  cpu_voltage_id,
	output reg  [4:0]  shared_io_in,
	// Configuration outputs
	output wire        twos_complement_sel,
	output wire        offset_range_coarse,
	output wire        cpu_code_or_io_sel,
	output wire [2:0]  first_fan_pulse_count,
	output wire [2:0]  second_fan_pulse_count,
	output wire [2:0]  third_fan_pulse_count,
	output wire [2:0]  fourth_fan_pulse_count
);

	// Register storage
	reg  [7:0]         assert_duration_limit_ff;
	reg  [7:0]         pulses_ff;
	reg  [7:0]         config_ff;
	reg                lock_ff;
	reg                overtemp_timer_int_flag_ff;
	reg                int_mask_ff;

	// Timer state
	reg  [1:0]         pin_sync_ff;
	reg                asserted_ff;
	reg  [PRESC_W-1:0] presc_ff;
	reg  [7:0]         assert_duration_count_ff;
	reg                assert_flag_lsb_ff;
	reg                exceed_ff;

	// Aux and shared pin synchronisers
	reg  [1:0]         aux_sync_ff;
	reg  [4:0]         shared_meta_ff;
	reg  [4:0]         shared_sync_ff;

	// Drive state
	reg                drive_low_ff;

	wire               asserted;
	wire               assert_rise;
	wire               tick;
	wire               rd_duration;
	wire               wr_config;
	wire [7:0]         duration_view;
	wire               exceed_now;
	wire               timer_event;
	wire               remote_a_hot;
	wire               local_hot;
	wire               remote_b_hot;

	localparam integer       PRESC_LAST_I = TICK_CYCLES - 1;
	localparam integer       MIN_TICKS_I  = `OTCR_MIN_REPORT_TICKS;
	localparam [PRESC_W-1:0] PRESC_LAST   = PRESC_LAST_I[PRESC_W-1:0];
	localparam [7:0]         MIN_TICKS    = MIN_TICKS_I[7:0];

	// Over-limit test in the selected format
	function hot_check;
		input [7:0] temp;
		input [7:0] limit;
		input       twos;
		input       en;
		begin
			// RQ13 disabled limit codes
			if (!en) begin
				hot_check = 1'b0;
			end else if (twos && limit == `OTCR_LIMIT_OFF_TWOS) begin
				hot_check = 1'b0;
			end else if (!twos && limit == `OTCR_LIMIT_OFF_OFFSET64) begin
				hot_check = 1'b0;
			end else if (twos) begin
				// RQ7 signed compare
				hot_check = ($signed(temp) > $signed(limit));
			end else begin
				hot_check = (temp > limit);
			end
		end
	endfunction

	assign rd_duration = rd_en && (addr == `OTCR_ADDR_DURATION);
	// RQ15 lock blocks config writes
	assign wr_config   = wr_en && (addr == `OTCR_ADDR_CONFIG) && !lock_ff;

	// RQ17 two-flop synchroniser
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			pin_sync_ff <= 2'b11;
		end else begin
			pin_sync_ff <= {pin_sync_ff[0], overtemp_pin_in};
		end
	end

	assign asserted    = !pin_sync_ff[1];
	assign assert_rise = asserted && !asserted_ff;
	assign tick        = asserted && (presc_ff == PRESC_LAST);

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			asserted_ff <= 1'b0;
		end else begin
			asserted_ff <= asserted;
		end
	end

	// Step prescaler, restarted by each assertion
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			presc_ff <= {PRESC_W{1'b0}};
		end else if (!asserted || assert_rise) begin
			presc_ff <= {PRESC_W{1'b0}};
		end else if (tick) begin
			presc_ff <= {PRESC_W{1'b0}};
		end else begin
			presc_ff <= presc_ff + {{(PRESC_W-1){1'b0}}, 1'b1};
		end
	end

	// Duration count, cleared by a read while released
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			assert_duration_count_ff <= `OTCR_RST_DURATION;
		end else if (rd_duration && !asserted) begin
			assert_duration_count_ff <= `OTCR_RST_DURATION;
		// RQ16 saturating step count
		end else if (tick && assert_duration_count_ff != 8'hFF) begin
			assert_duration_count_ff <= assert_duration_count_ff + 8'h01;
		end
	end

	// RQ2 set on assertion, set wins over read
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			assert_flag_lsb_ff <= 1'b0;
		end else if (assert_rise) begin
			assert_flag_lsb_ff <= 1'b1;
		end else if (rd_duration) begin
			assert_flag_lsb_ff <= 1'b0;
		end
	end

	// RQ1 upper bits hidden below 45.52 ms
	// RQ3 full count once past it
	assign duration_view = (assert_duration_count_ff >= MIN_TICKS) ?
		assert_duration_count_ff : {7'h00, assert_flag_lsb_ff};

	// RQ4 duration beyond limit
	assign exceed_now = asserted &&
		(assert_duration_count_ff > assert_duration_limit_ff);

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			exceed_ff <= 1'b0;
		end else begin
			exceed_ff <= exceed_now;
		end
	end

	// RQ5 zero limit fires on assertion
	// RQ4 fires once as the limit is passed
	assign timer_event =
		(assert_rise && assert_duration_limit_ff == 8'h00) ||
		(exceed_now && !exceed_ff);

	// Sticky flag, write one clears, set wins
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			overtemp_timer_int_flag_ff <= 1'b0;
		end else if (timer_event) begin
			overtemp_timer_int_flag_ff <= 1'b1;
		end else if (wr_en && addr == `OTCR_ADDR_INT_STATUS2 &&
				wdata[`OTCR_INT_TIMER_BIT]) begin
			overtemp_timer_int_flag_ff <= 1'b0;
		end
	end

	assign irq = overtemp_timer_int_flag_ff && int_mask_ff;

	// Writable registers
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			assert_duration_limit_ff <= `OTCR_RST_LIMIT;
			pulses_ff                <= `OTCR_RST_PULSES;
			int_mask_ff              <= 1'b0;
		end else if (wr_en) begin
			case (addr)
				`OTCR_ADDR_LIMIT: begin
					assert_duration_limit_ff <= wdata;
				end
				`OTCR_ADDR_PULSES: begin
					pulses_ff <= wdata;
				end
				`OTCR_ADDR_INT_MASK2: begin
					int_mask_ff <= wdata[`OTCR_INT_TIMER_BIT];
				end
				default: begin
					pulses_ff <= pulses_ff;
				end
			endcase
		end
	end

	// RQ14 configuration reset value
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			config_ff <= `OTCR_RST_CONFIG;
		end else if (wr_config) begin
			config_ff <= wdata;
		end
	end

	// RQ15 lock sets once, reset clears
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			lock_ff <= 1'b0;
		end else if (wr_en && addr == `OTCR_ADDR_LOCK && wdata[`OTCR_LOCK_BIT]) begin
			lock_ff <= 1'b1;
		end
	end

	// Read data, one cycle after the strobe
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			rdata <= `OTCR_RST_BYTE;
		end else if (rd_en) begin
			case (addr)
				`OTCR_ADDR_INT_STATUS2: begin
					rdata <= {2'b00, overtemp_timer_int_flag_ff, 5'h00};
				end
				`OTCR_ADDR_DURATION: begin
					rdata <= duration_view;
				end
				`OTCR_ADDR_LIMIT: begin
					rdata <= assert_duration_limit_ff;
				end
				`OTCR_ADDR_PULSES: begin
					rdata <= pulses_ff;
				end
				`OTCR_ADDR_CONFIG: begin
					rdata <= config_ff;
				end
				`OTCR_ADDR_LOCK: begin
					rdata <= {7'h00, lock_ff};
				end
				`OTCR_ADDR_INT_MASK2: begin
					rdata <= {2'b00, int_mask_ff, 5'h00};
				end
				default: begin
					rdata <= `OTCR_RST_BYTE;
				end
			endcase
		end else begin
			rdata <= `OTCR_RST_BYTE;
		end
	end

	// RQ12 per-channel output enables
	assign remote_a_hot = hot_check(remote_a_temp, remote_a_limit,
		config_ff[`OTCR_CFG_TWOS_BIT], config_ff[`OTCR_CFG_REMOTE_A_BIT]);
	assign local_hot    = hot_check(local_temp, local_limit,
		config_ff[`OTCR_CFG_TWOS_BIT], config_ff[`OTCR_CFG_LOCAL_BIT]);
	assign remote_b_hot = hot_check(remote_b_temp, remote_b_limit,
		config_ff[`OTCR_CFG_TWOS_BIT], config_ff[`OTCR_CFG_REMOTE_B_BIT]);

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			drive_low_ff <= 1'b0;
		end else begin
			drive_low_ff <= remote_a_hot || local_hot || remote_b_hot;
		end
	end

	// Open drain: only ever pulls low
	assign overtemp_pin_out = 1'b0;
	assign overtemp_pin_oe  = drive_low_ff;

	// RQ7 format select
	assign twos_complement_sel = config_ff[`OTCR_CFG_TWOS_BIT];
	assign offset_range_coarse = config_ff[`OTCR_CFG_OFFSET_BIT];

	// RQ8 offset in half-degree units
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			temp_offset_half <= 9'h000;
		end else if (offset_range_coarse) begin
			temp_offset_half <= {temp_offset_code, 1'b0};
		end else begin
			temp_offset_half <= {temp_offset_code[7], temp_offset_code};
		end
	end

	// RQ9 aux direction
	assign aux_io_oe  = aux_io_enable && config_ff[`OTCR_CFG_AUX_DIR_BIT];
	// RQ10 aux polarity
	assign aux_io_out = config_ff[`OTCR_CFG_AUX_POL_BIT] ? aux_io_value : !aux_io_value;

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			aux_sync_ff <= 2'b00;
		end else begin
			aux_sync_ff <= {aux_sync_ff[0], aux_io_in};
		end
	end

	assign aux_io_level = aux_sync_ff[1];

	// RQ11 shared pin function
	assign cpu_code_or_io_sel = config_ff[`OTCR_CFG_CODE_IO_BIT];

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			shared_meta_ff <= 5'h00;
			shared_sync_ff <= 5'h00;
		end else begin
			shared_meta_ff <= shared_pin_in;
			shared_sync_ff <= shared_meta_ff;
		end
	end

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			cpu_voltage_id <= 5'h00;
			shared_io_in   <= 5'h00;
		end else if (cpu_code_or_io_sel) begin
			cpu_voltage_id <= 5'h00;
			shared_io_in   <= shared_sync_ff;
		end else begin
			cpu_voltage_id <= shared_sync_ff;
			shared_io_in   <= 5'h00;
		end
	end

	// RQ6 pulses counted per fan
	assign first_fan_pulse_count  = {1'b0, pulses_ff[1:0]} + 3'h1;
	assign second_fan_pulse_count = {1'b0, pulses_ff[3:2]} + 3'h1;
	assign third_fan_pulse_count  = {1'b0, pulses_ff[5:4]} + 3'h1;
	assign fourth_fan_pulse_count = {1'b0, pulses_ff[7:6]} + 3'h1;

endmodule // otcr_regs
`default_nettype wire

// ### otcr_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
module otcr_pin_model #(
	parameter int SKEW_NS = 3
) (
	// Clock and command
	input  wire logic clk,
	input  wire logic ext_low,
	// Shared pin
	input  wire logic dev_oe,
	output wire logic pin
);
	logic hold_ff = 1'b0;
	always @(posedge clk) hold_ff <= #SKEW_NS ext_low;
	assign pin = (hold_ff || dev_oe) ? 1'b0 : 1'b1;
endmodule // otcr_pin_model
`default_nettype wire

// ### otcr_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module otcr_assertions (
	// Clock, reset, register port
	input wire logic       clk,
	input wire logic       rst,
	input wire logic [7:0] addr,
	input wire logic       wr_en,
	input wire logic       rd_en,
	input wire logic [7:0] rdata,
	input wire logic       irq,
	// Pins and channel limits
	input wire logic       overtemp_pin_out,
	input wire logic       overtemp_pin_oe,
	input wire logic [7:0] remote_a_temp,
	input wire logic [7:0] local_temp,
	input wire logic [7:0] remote_b_temp,
	input wire logic [7:0] remote_a_limit,
	input wire logic [7:0] local_limit,
	input wire logic [7:0] remote_b_limit,
	input wire logic       aux_io_enable,
	input wire logic       aux_io_oe,
	input wire logic [4:0] cpu_voltage_id,
	input wire logic [4:0] shared_io_in,
	// Configuration outputs
	input wire logic       twos_complement_sel,
	input wire logic       offset_range_coarse,
	input wire logic       cpu_code_or_io_sel,
	input wire logic [2:0] first_fan_pulse_count
);
	wire [7:0] off_code = twos_complement_sel ? 8'h80 : 8'h00;
	// Any channel above its limit in the current format
	wire hot_any = twos_complement_sel ?
		($signed(remote_a_temp) > $signed(remote_a_limit) ||
		$signed(local_temp) > $signed(local_limit) ||
		$signed(remote_b_temp) > $signed(remote_b_limit)) :
		(remote_a_temp > remote_a_limit || local_temp > local_limit ||
		remote_b_temp > remote_b_limit);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	// All channel limits at disabled code
	sequence s_all_off;
		remote_a_limit == off_code && local_limit == off_code && remote_b_limit == off_code;
	endsequence
	// Previous cycle wrote this address
	sequence s_wr_at(logic [7:0] a);
		$past(wr_en) && $past(addr) == a;
	endsequence
	chk_read_idle: assert property (!$past(rd_en) |-> rdata == 8'h00)
		else $error("rdata not idle");
	chk_pin_drain: assert property (overtemp_pin_oe |->
		overtemp_pin_out == 1'b0 && $past(hot_any))
		else $error("pin driven without hot channel");
	chk_limit_off: assert property (s_all_off |=> !overtemp_pin_oe)
		else $error("disabled limit drives pin");
	chk_cfg_write: assert property ($changed({twos_complement_sel, offset_range_coarse,
		cpu_code_or_io_sel}) |-> s_wr_at(8'h7C))
		else $error("config changed without write");
	chk_fan_write: assert property ($changed(first_fan_pulse_count) |-> s_wr_at(8'h7B))
		else $error("pulse count changed without write");
	chk_fan_range: assert property (first_fan_pulse_count inside {[3'h1:3'h4]})
		else $error("pulse count out of range");
	chk_aux_dir: assert property (aux_io_oe |-> aux_io_enable)
		else $error("aux driven while disabled");
	chk_vid_off: assert property ($past(cpu_code_or_io_sel) |-> cpu_voltage_id == 5'h00)
		else $error("vid in io mode");
	chk_io_off: assert property (!$past(cpu_code_or_io_sel) |-> shared_io_in == 5'h00)
		else $error("io in vid mode");
	chk_irq_clear: assert property ($fell(irq) |-> $past(wr_en))
		else $error("irq fell without write");
endmodule // otcr_assertions
bind otcr_regs otcr_assertions chk_u (.clk, .rst, .addr, .wr_en, .rd_en, .rdata, .irq,
	.overtemp_pin_out, .overtemp_pin_oe, .remote_a_temp, .local_temp, .remote_b_temp,
	.remote_a_limit, .local_limit, .remote_b_limit,
	.aux_io_enable, .aux_io_oe, .cpu_voltage_id, .shared_io_in, .twos_complement_sel,
	.offset_range_coarse, .cpu_code_or_io_sel, .first_fan_pulse_count);
`default_nettype wire

// ### test_overtemp_timer_config_regs.sv
`timescale 1ns/1ps
`default_nettype none
module test_overtemp_timer_config_regs;
	logic clk = 0, rst = 1, wr_en = 0, rd_en = 0, ext_low = 0, irq, overtemp_pin_in;
	logic aux_io_enable = 0, aux_io_value = 0, aux_io_in = 0, aux_io_out, aux_io_oe;
	logic overtemp_pin_out, overtemp_pin_oe, aux_io_level;
	logic twos_complement_sel, offset_range_coarse, cpu_code_or_io_sel;
	logic [7:0] addr = 0, wdata = 0, rdata, temp_offset_code = 0;
	logic [7:0] remote_a_temp = 0, local_temp = 0, remote_b_temp = 0;
	logic [7:0] remote_a_limit = 0, local_limit = 0, remote_b_limit = 0;
	logic [8:0] temp_offset_half;
	logic [4:0] shared_pin_in = 0, cpu_voltage_id, shared_io_in;
	logic [2:0] first_fan_pulse_count, second_fan_pulse_count;
	logic [2:0] third_fan_pulse_count, fourth_fan_pulse_count;
	int bad_count = 0, tests_run = 0, lk = 0;
	int m[int];
	logic [7:0] al[$] = {8'h42, 8'h79, 8'h7A, 8'h7B, 8'h7C, 8'h80, 8'h81, 8'h55};
	logic [23:0] tab[$] = {24'h21403F, 24'h414080, 24'h814041, 24'h41F010, 24'h40F010,
		24'h209000, 24'h01403F};

	otcr_regs #(.TICK_CYCLES(8)) uut (.clk, .rst, .addr, .wdata, .wr_en, .rd_en, .rdata, .irq,
		.overtemp_pin_in, .overtemp_pin_out, .overtemp_pin_oe, .remote_a_temp, .local_temp,
		.remote_b_temp, .remote_a_limit, .local_limit, .remote_b_limit, .temp_offset_code,
		.temp_offset_half, .aux_io_enable, .aux_io_value, .aux_io_in, .aux_io_out, .aux_io_oe,
		.aux_io_level, .shared_pin_in, .cpu_voltage_id, .shared_io_in, .twos_complement_sel,
		.offset_range_coarse, .cpu_code_or_io_sel, .first_fan_pulse_count,
		.second_fan_pulse_count, .third_fan_pulse_count, .fourth_fan_pulse_count);
	otcr_pin_model pm (.clk, .ext_low, .dev_oe(overtemp_pin_oe), .pin(overtemp_pin_in));

	always #10 clk = ~clk;

	task automatic chk(input logic [8:0] seen, input logic [8:0] exp, input string nm);
		tests_run++;
		if (seen !== exp) begin
			bad_count++;
			$display("[ERR] %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	function automatic logic [7:0] mv(input logic [7:0] a);
		return m.exists(a) ? 8'(m[a]) : 8'h00;
	endfunction
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr_en <= 1;
		@(posedge clk);
		wr_en <= 0;
		if (a == 8'h7A || a == 8'h7B || (a == 8'h7C && lk == 0)) m[a] = d;
		if (a == 8'h81) m[a] = d & 8'h20;
		if (a == 8'h80 && d[0]) lk = 1;
		if (a == 8'h80 && d[0]) m[a] = 1;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		addr <= a;
		rd_en <= 1;
		@(posedge clk);
		rd_en <= 0;
		#1 chk(rdata, e, "rdata");
	endtask
	task automatic do_reset();
		rst <= 1;
		repeat (3) @(posedge clk);
		rst <= 0;
		lk = 0;
		m = '{8'h7A: 0, 8'h7B: 8'h55, 8'h7C: 1, 8'h80: 0, 8'h81: 0};
	endtask
	task automatic pulse(input int n);
		ext_low <= 1;
		repeat (n) @(posedge clk);
		ext_low <= 0;
		repeat (4) @(posedge clk);
	endtask
	task automatic final_report();
		if (bad_count == 0 && tests_run > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	initial begin
		#200000;
		bad_count++;
		final_report();
	end

	initial begin
		logic [7:0] d;
		logic [31:0] r;
		logic e;
		d = 8'($urandom(2));
		do_reset();
		foreach (al[i]) rd(al[i], mv(al[i]));
		chk(twos_complement_sel, 1, "twos");
		wr(8'h79, 8'($urandom));
		rd(8'h79, 8'h00);
		for (int k = 0; k < 5; k++) begin
			d = (k < 4) ? 8'(k * 8'h55) : 8'($urandom);
			wr(8'h7B, d);
			#1 chk(first_fan_pulse_count, d[1:0] + 3'h1, "first_fan_pulse_count");
			chk(second_fan_pulse_count, d[3:2] + 3'h1, "fan2");
			chk(third_fan_pulse_count, d[5:4] + 3'h1, "third_fan_pulse_count");
			chk(fourth_fan_pulse_count, d[7:6] + 3'h1, "fourth_fan_pulse_count");
			rd(8'h7B, mv(8'h7B));
		end
		for (int k = 0; k < 4; k++) begin
			d = (k < 2) ? 8'(k * 8'h1F) : 8'($urandom) & 8'h1F;
			r = $urandom;
			@(posedge clk);
			{aux_io_enable, aux_io_value, aux_io_in} <= r[2:0];
			shared_pin_in <= r[7:3];
			temp_offset_code <= r[15:8];
			wr(8'h7C, d);
			repeat (3) @(posedge clk);
			#1 chk(twos_complement_sel, d[0], "twos");
			chk(offset_range_coarse, d[1], "coarse");
			chk(temp_offset_half, d[1] ? {r[15:8], 1'b0} : {r[15], r[15:8]}, "ofs");
			chk(aux_io_oe, r[2] & d[2], "aux_oe");
			chk(aux_io_level, r[0], "aux_lvl");
			chk(aux_io_out, r[1] ^ !d[3], "aux_out");
			chk(cpu_voltage_id, d[4] ? 5'h00 : r[7:3], "vid");
			chk(shared_io_in, d[4] ? r[7:3] : 5'h00, "gpio");
		end
		wr(8'h7C, 8'h01);
		wr(8'h81, 8'h20);
		// Short assertion, zero limit
		pulse(4);
		#1 chk(irq, 1, "irq");
		rd(8'h42, 8'h20);
		wr(8'h42, 8'h20);
		#1 chk(irq, 0, "irq");
		rd(8'h79, 8'h01);
		rd(8'h79, 8'h00);
		// Four steps against a limit of two
		wr(8'h7A, 8'h02);
		ext_low <= 1;
		repeat (21) @(posedge clk);
		rd(8'h79, 8'h02);
		rd(8'h42, 8'h00);
		repeat (10) @(posedge clk);
		ext_low <= 0;
		repeat (4) @(posedge clk);
		#1 chk(irq, 1, "irq");
		rd(8'h79, 8'h04);
		rd(8'h79, 8'h00);
		rd(8'h42, 8'h20);
		wr(8'h42, 8'h20);
		wr(8'h7A, 8'hFF);
		pulse(2100);
		rd(8'h79, 8'hFF);
		rd(8'h42, 8'h00);
		rd(8'h79, 8'h00);
		for (int k = 0; k < 12; k++) begin
			r = (k < tab.size()) ? 32'(tab[k]) : $urandom;
			@(posedge clk);
			{remote_a_temp, local_temp, remote_b_temp} <= {3{r[15:8]}};
			{remote_a_limit, local_limit, remote_b_limit} <= {3{r[7:0]}};
			wr(8'h7C, r[23:16]);
			repeat (3) @(posedge clk);
			e = |r[23:21] && r[7:0] != {r[16], 7'h00}
				&& (r[16] ? $signed(r[15:8]) > $signed(r[7:0]) : r[15:8] > r[7:0]);
			#1 chk(overtemp_pin_oe, e, "oe");
		end
		do_reset();
		rd(8'h7C, 8'h01);
		wr(8'h80, 8'h01);
		wr(8'h7C, 8'h1E);
		rd(8'h7C, mv(8'h7C));
		do_reset();
		wr(8'h7C, 8'h1E);
		rd(8'h7C, mv(8'h7C));
		final_report();
	end
endmodule // test_overtemp_timer_config_regs
`default_nettype wire
